/* cai_pkg.sv */
`default_nettype none
package cai_pkg;

  // machine widths
  localparam int WORD_W  = 32;
  localparam int DWORD_W = 64;
  localparam int ADDR_W  = 18;
  localparam int OPC_W   = 7;

  // instruction operation codes handled here
  localparam logic [6:0] OPC_CMP_BYTE  = 7'h0B;
  localparam logic [6:0] OPC_CMP_ZERO  = 7'h15;
  localparam logic [6:0] OPC_CMP_INDEX = 7'h16;
  localparam logic [6:0] OPC_CMP_SEL   = 7'h35;
  localparam logic [6:0] OPC_CMP_ALG   = 7'h14;
  localparam logic [6:0] OPC_ADD_ACC   = 7'h06;
  localparam logic [6:0] OPC_ADD_HALF  = 7'h12;
  localparam logic [6:0] OPC_ADD_BYTE  = 7'h02;

  // operand-select field codes
  localparam logic [1:0] SEL_MEM  = 2'h0;
  localparam logic [1:0] SEL_ACCA = 2'h1;
  localparam logic [1:0] SEL_ACCB = 2'h2;
  localparam logic [1:0] SEL_ACCD = 2'h3;

  // condition indicator encodings
  localparam logic [1:0] COND_LOW  = 2'h1;
  localparam logic [1:0] COND_EQ   = 2'h2;
  localparam logic [1:0] COND_HIGH = 2'h3;

  // register word addresses on the plain port
  localparam logic [2:0] OFS_ACCA   = 3'h0;
  localparam logic [2:0] OFS_ACCB   = 3'h1;
  localparam logic [2:0] OFS_IDX1   = 3'h2;
  localparam logic [2:0] OFS_IDX2   = 3'h3;
  localparam logic [2:0] OFS_IDX3   = 3'h4;
  localparam logic [2:0] OFS_STATUS = 3'h5;

  // status register field positions
  localparam int STS_COND_LSB = 0;
  localparam int STS_OVF_BIT  = 2;

  // reset values
  localparam logic [31:0] RST_ACC  = 32'h0000_0000;
  localparam logic [17:0] RST_IDX  = 18'h0_0000;
  localparam logic [1:0]  RST_COND = 2'h0;

  // one instruction as issued by the sequencer
  typedef struct packed {
    logic [6:0]  opcode;
    logic [1:0]  mSel;
    logic        cEn;
    logic        lit;
    logic [17:0] addr;
    logic [63:0] mem;
  } cai_cmd_t;

endpackage
`default_nettype wire

/* cai_compare_add.sv */
// Overview of operation
// - unsigned byte compare of selected accumulator byte
// - magnitude compare codes: less 1, equal 2, greater 3
// - compares act only when condition enable set
// - byte compare literal uses low address byte
// - signed compare to zero of memory or accumulator
// - compare to zero ignores literal flag
// - unsigned index register compare, literal whole field
// - selective compare bits where secondary holds one
// - selective codes: none 1, all 2, some 3
// - selective literal sign-extends address to 32 bits
// - signed compare of accumulator against memory
// - signed compare literal sign-extended to width
// - add word or double word into accumulator
// - overflow when sign and numeric carries differ
// - add sets condition from signed result
// - add literal sign-extended to accumulator width
// - half-word add to left, right, or extended
// - extended half-word carry reaches left half
// - half-word overflow from sign versus position one
// - half-word literal is low sixteen bits signed
// - byte add into selected accumulator byte
// - byte add carry ripples into left bytes
`timescale 1ns/1ns
`default_nettype none
module cai_compare_add #(
  parameter int REG_AW = 3
) (
  input  wire logic                 clk_sys,
  input  wire logic                 reset,
  // instruction side
  input  wire logic                 cmdValid,
  input  wire cai_pkg::cai_cmd_t    cmd,
  output logic                      opDone,
  output logic [1:0]                condCode,
  output logic                      overflowFlag,
  output logic [31:0]               accAOut,
  output logic [31:0]               accBOut,
  // register port
  input  wire logic [REG_AW-1:0]    regAddr,
  input  wire logic [31:0]          regWrData,
  input  wire logic                 regWr,
  input  wire logic                 regRd,
  output logic [31:0]               regRdData
);

  // elaboration check: six word addresses need at least three bits
  if (REG_AW < 3)
  begin
    $error("REG_AW must be at least 3");
  end

  // all state of the block
  typedef struct packed {
    logic [31:0] accA;
    logic [31:0] accB;
    logic [17:0] idx1;
    logic [17:0] idx2;
    logic [17:0] idx3;
    logic [1:0]  cond;
    logic        ovf;
    logic        done;
    logic [31:0] rdData;
  } cai_state_t;

  cai_state_t stQ;
  cai_state_t stD;

  // magnitude compare result to indicator code
  function automatic logic [1:0] cmpCode(input logic lt, input logic eq);
    logic [1:0] c;
    c = lt ? cai_pkg::COND_LOW : (eq ? cai_pkg::COND_EQ : cai_pkg::COND_HIGH);
    return c;
  endfunction

  // sign/zero test of a signed value, given its sign and zero flags
  function automatic logic [1:0] signCode(input logic neg, input logic zero);
    logic [1:0] c;
    c = neg ? cai_pkg::COND_LOW : (zero ? cai_pkg::COND_EQ : cai_pkg::COND_HIGH);
    return c;
  endfunction

  // working values of the datapath
  logic [63:0] accD;
  logic [31:0] litW;
  logic [63:0] litD;
  logic [31:0] opW;
  logic [63:0] opD;
  logic [31:0] selAcc;
  logic [4:0]  byteShift;
  logic [7:0]  accByte;
  logic [7:0]  opByte;
  logic [31:0] idxVal;
  logic [31:0] diffBits;
  logic [31:0] eqBits;
  logic [32:0] sum33;
  logic [64:0] sum65;
  logic [16:0] sum17;
  logic [15:0] opHalf;
  logic [31:0] addend;
  logic [31:0] res32;
  logic        ovfNow;
  logic        isWrite;
  logic [1:0]  condNew;
  logic        condUpd;

  // next-state logic: bus access first, instruction last so it wins
  always_comb
  begin
    stD       = stQ;
    stD.done  = 1'b0;
    stD.rdData = 32'h0000_0000;
    accD      = {stQ.accA, stQ.accB};
    litW      = {{14{cmd.addr[17]}}, cmd.addr};
    litD      = {{46{cmd.addr[17]}}, cmd.addr};
    opW       = cmd.lit ? litW : cmd.mem[31:0];
    opD       = cmd.lit ? litD : cmd.mem;
    selAcc    = (cmd.mSel == cai_pkg::SEL_ACCB) ? stQ.accB : stQ.accA;
    // byte 1 is leftmost, so code 00 sits at bit 24
    byteShift = {~cmd.mSel, 3'b000};
    accByte   = 8'(stQ.accA >> byteShift);
    opByte    = cmd.lit ? cmd.addr[7:0] : cmd.mem[7:0];
    opHalf    = cmd.lit ? cmd.addr[15:0] : cmd.mem[15:0];
    idxVal    = 32'h0000_0000;
    diffBits  = (stQ.accA ^ opW) & stQ.accB;
    eqBits    = ~(stQ.accA ^ opW) & stQ.accB;
    sum33     = 33'h0_0000_0000;
    sum65     = 65'h0_0000_0000_0000_0000;
    sum17     = 17'h0_0000;
    addend    = 32'h0000_0000;
    res32     = 32'h0000_0000;
    ovfNow    = 1'b0;
    isWrite   = 1'b0;
    condNew   = stQ.cond;
    condUpd   = 1'b0;

    // register writes from software
    if (regWr)
    begin
      if (regAddr == REG_AW'(cai_pkg::OFS_ACCA))
        stD.accA = regWrData;
      else if (regAddr == REG_AW'(cai_pkg::OFS_ACCB))
        stD.accB = regWrData;
      else if (regAddr == REG_AW'(cai_pkg::OFS_IDX1))
        stD.idx1 = regWrData[17:0];
      else if (regAddr == REG_AW'(cai_pkg::OFS_IDX2))
        stD.idx2 = regWrData[17:0];
      else if (regAddr == REG_AW'(cai_pkg::OFS_IDX3))
        stD.idx3 = regWrData[17:0];
      else if (regAddr == REG_AW'(cai_pkg::OFS_STATUS))
      begin
        // writing one clears the sticky overflow
        if (regWrData[cai_pkg::STS_OVF_BIT])
          stD.ovf = 1'b0;
        stD.cond = regWrData[cai_pkg::STS_COND_LSB +: 2];
      end
    end

    // register reads, answered in the next cycle; unmapped reads give zero
    if (regRd)
    begin
      if (regAddr == REG_AW'(cai_pkg::OFS_ACCA))
        stD.rdData = stQ.accA;
      else if (regAddr == REG_AW'(cai_pkg::OFS_ACCB))
        stD.rdData = stQ.accB;
      else if (regAddr == REG_AW'(cai_pkg::OFS_IDX1))
        stD.rdData = {14'h0000, stQ.idx1};
      else if (regAddr == REG_AW'(cai_pkg::OFS_IDX2))
        stD.rdData = {14'h0000, stQ.idx2};
      else if (regAddr == REG_AW'(cai_pkg::OFS_IDX3))
        stD.rdData = {14'h0000, stQ.idx3};
      else if (regAddr == REG_AW'(cai_pkg::OFS_STATUS))
        stD.rdData = {29'h0000_0000, stQ.ovf, stQ.cond};
    end

    // instruction execution, one command per cycle
    if (cmdValid)
    begin
      stD.done = 1'b1;
      case (cmd.opcode)
        cai_pkg::OPC_CMP_BYTE:
        begin
          if (cmd.cEn)
          begin
            condUpd = 1'b1;
            condNew = cmpCode(accByte < opByte, accByte == opByte);
          end
        end
        cai_pkg::OPC_CMP_ZERO:
        begin
          // literal flag and address fields play no part here
          if (cmd.cEn)
          begin
            condUpd = 1'b1;
            if (cmd.mSel == cai_pkg::SEL_MEM)
              condNew = signCode(cmd.mem[31], cmd.mem[31:0] == 32'h0000_0000);
            else if (cmd.mSel == cai_pkg::SEL_ACCD)
              condNew = signCode(accD[63], accD == 64'h0000_0000_0000_0000);
            else
              condNew = signCode(selAcc[31], selAcc == 32'h0000_0000);
          end
        end
        cai_pkg::OPC_CMP_INDEX:
        begin
          if (cmd.cEn && cmd.mSel != cai_pkg::SEL_MEM)
          begin
            if (cmd.mSel == cai_pkg::SEL_ACCA)
              idxVal = {14'h0000, stQ.idx1};
            else if (cmd.mSel == cai_pkg::SEL_ACCB)
              idxVal = {14'h0000, stQ.idx2};
            else
              idxVal = {14'h0000, stQ.idx3};
            // literal: the whole field as an unsigned operand
            opW = cmd.lit ? {14'h0000, cmd.addr} : cmd.mem[31:0];
            condUpd = 1'b1;
            condNew = cmpCode(idxVal < opW, idxVal == opW);
          end
        end
        cai_pkg::OPC_CMP_SEL:
        begin
          // operand select is ignored; secondary accumulator is the mask
          if (cmd.cEn)
          begin
            condUpd = 1'b1;
            // an empty mask compares nothing and so counts as all equal
            if (stQ.accB != 32'h0000_0000 && eqBits == 32'h0000_0000)
              condNew = cai_pkg::COND_LOW;
            else if (diffBits == 32'h0000_0000)
              condNew = cai_pkg::COND_EQ;
            else
              condNew = cai_pkg::COND_HIGH;
          end
        end
        cai_pkg::OPC_CMP_ALG:
        begin
          if (cmd.cEn && cmd.mSel != cai_pkg::SEL_MEM)
          begin
            condUpd = 1'b1;
            if (cmd.mSel == cai_pkg::SEL_ACCD)
              condNew = cmpCode($signed(accD) < $signed(opD), accD == opD);
            else
              condNew = cmpCode($signed(selAcc) < $signed(opW), selAcc == opW);
          end
        end
        cai_pkg::OPC_ADD_ACC:
        begin
          if (cmd.mSel == cai_pkg::SEL_ACCD)
          begin
            sum65 = {1'b0, accD} + {1'b0, opD};
            // carry out of sign versus carry into it
            ovfNow = sum65[64] ^ (accD[63] ^ opD[63] ^ sum65[63]);
            stD.accA = sum65[63:32];
            stD.accB = sum65[31:0];
            condNew = signCode(sum65[63], sum65[63:0] == 64'h0000_0000_0000_0000);
            condUpd = cmd.cEn;
          end
          else if (cmd.mSel != cai_pkg::SEL_MEM)
          begin
            sum33 = {1'b0, selAcc} + {1'b0, opW};
            ovfNow = sum33[32] ^ (selAcc[31] ^ opW[31] ^ sum33[31]);
            isWrite = 1'b1;
            res32 = sum33[31:0];
            condNew = signCode(res32[31], res32 == 32'h0000_0000);
            condUpd = cmd.cEn;
          end
        end
        cai_pkg::OPC_ADD_HALF:
        begin
          if (cmd.mSel == cai_pkg::SEL_ACCA)
          begin
            // left half holds the sign, so overflow is direct
            sum17 = {1'b0, stQ.accA[31:16]} + {1'b0, opHalf};
            ovfNow = sum17[16] ^ (stQ.accA[31] ^ opHalf[15] ^ sum17[15]);
            res32 = {sum17[15:0], stQ.accA[15:0]};
          end
          else if (cmd.mSel == cai_pkg::SEL_ACCB)
          begin
            // plain right half: carry is dropped, left half kept
            sum17 = {1'b0, stQ.accA[15:0]} + {1'b0, opHalf};
            res32 = {stQ.accA[31:16], sum17[15:0]};
          end
          else
          begin
            addend = {{16{opHalf[15]}}, opHalf};
            sum33 = {1'b0, stQ.accA} + {1'b0, addend};
            ovfNow = sum33[32] ^ (stQ.accA[31] ^ addend[31] ^ sum33[31]);
            res32 = sum33[31:0];
          end
          stD.accA = res32;
          condNew = signCode(res32[31], res32 == 32'h0000_0000);
          condUpd = cmd.cEn;
        end
        cai_pkg::OPC_ADD_BYTE:
        begin
          // shifted addend lets the carry ripple leftward
          addend = 32'({24'h00_0000, opByte} << byteShift);
          sum33 = {1'b0, stQ.accA} + {1'b0, addend};
          ovfNow = sum33[32] ^ (stQ.accA[31] ^ addend[31] ^ sum33[31]);
          stD.accA = sum33[31:0];
          condNew = signCode(sum33[31], sum33[31:0] == 32'h0000_0000);
          condUpd = cmd.cEn;
        end
        default:
        begin
          // other operations are not executed by this unit
          condUpd = 1'b0;
        end
      endcase

      // word add writes back to the selected accumulator
      if (isWrite)
      begin
        if (cmd.mSel == cai_pkg::SEL_ACCB)
          stD.accB = res32;
        else
          stD.accA = res32;
      end
      if (condUpd)
        stD.cond = condNew;
      // overflow is sticky; a set beats a clear in the same cycle
      if (ovfNow)
        stD.ovf = 1'b1;
    end
  end

  // state register
  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      stQ.accA   <= cai_pkg::RST_ACC;
      stQ.accB   <= cai_pkg::RST_ACC;
      stQ.idx1   <= cai_pkg::RST_IDX;
      stQ.idx2   <= cai_pkg::RST_IDX;
      stQ.idx3   <= cai_pkg::RST_IDX;
      stQ.cond   <= cai_pkg::RST_COND;
      stQ.ovf    <= 1'b0;
      stQ.done   <= 1'b0;
      stQ.rdData <= 32'h0000_0000;
    end
    else
    begin
      stQ <= stD;
    end
  end

  // outputs straight from the state flops
  assign opDone       = stQ.done;
  assign condCode     = stQ.cond;
  assign overflowFlag = stQ.ovf;
  assign accAOut      = stQ.accA;
  assign accBOut      = stQ.accB;
  assign regRdData    = stQ.rdData;

endmodule
`default_nettype wire

/* cai_compare_add_monitor.sv */
`timescale 1ns/1ns
`default_nettype none
module cai_compare_add_monitor #(
  parameter int REG_AW = 3
) (
  input wire logic              clk_sys,
  input wire logic              reset,
  input wire logic              cmdValid,
  input wire cai_pkg::cai_cmd_t cmd,
  input wire logic              opDone,
  input wire logic [1:0]        condCode,
  input wire logic              overflowFlag,
  input wire logic [31:0]       accAOut,
  input wire logic [31:0]       accBOut,
  input wire logic [REG_AW-1:0] regAddr,
  input wire logic [31:0]       regWrData,
  input wire logic              regWr,
  input wire logic              regRd,
  input wire logic [31:0]       regRdData
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  // bus writes are excluded because a write in the same cycle may move state legally
  wire logic isCmp = cmdValid && !regWr && cmd.opcode inside {cai_pkg::OPC_CMP_BYTE,
    cai_pkg::OPC_CMP_ZERO, cai_pkg::OPC_CMP_INDEX, cai_pkg::OPC_CMP_SEL, cai_pkg::OPC_CMP_ALG};
  wire logic isAdd = cmdValid && !regWr && cmd.opcode inside {cai_pkg::OPC_ADD_ACC,
    cai_pkg::OPC_ADD_HALF, cai_pkg::OPC_ADD_BYTE};
  done_after_cmd_a: assert property (cmdValid |=> opDone)
    else $error("no done pulse after a command");
  done_cause_a: assert property (opDone |-> $past(cmdValid))
    else $error("done pulse without a command");
  noop_cond_a: assert property (isCmp && !cmd.cEn |=> $stable(condCode))
    else $error("disabled compare moved the condition");
  cmp_keeps_acc_a: assert property (isCmp |=> $stable(accAOut) && $stable(accBOut))
    else $error("compare altered an accumulator");
  add_keeps_cond_a: assert property (isAdd && !cmd.cEn |=> $stable(condCode))
    else $error("add without enable moved the condition");
  ovf_sticky_a: assert property (overflowFlag && !regWr |=> overflowFlag)
    else $error("overflow dropped without a clear");
  zero_acca_a: assert property (isCmp && cmd.cEn && cmd.opcode == cai_pkg::OPC_CMP_ZERO
    && cmd.mSel == cai_pkg::SEL_ACCA |=> condCode == (($past(accAOut) == 32'h0000_0000)
    ? cai_pkg::COND_EQ : ($signed($past(accAOut)) < 0) ? cai_pkg::COND_LOW : cai_pkg::COND_HIGH))
    else $error("zero compare of primary gave a wrong code");
  mask_empty_a: assert property (isCmp && cmd.cEn && cmd.opcode == cai_pkg::OPC_CMP_SEL
    && accBOut == 32'h0000_0000 |=> condCode == cai_pkg::COND_EQ)
    else $error("empty mask did not give equal");
endmodule
`default_nettype wire

/* cai_seq_model.sv */
`timescale 1ns/1ns
`default_nettype none
module cai_seq_model (
  input  wire logic              clk_sys,
  input  wire logic              reset,
  input  wire logic              issue,
  input  wire cai_pkg::cai_cmd_t issueCmd,
  output var  logic              cmdValid,
  output var  cai_pkg::cai_cmd_t cmd
);
  initial
  begin
    cmdValid = 1'b0;
    cmd      = '0;
  end
  // idle fields toggle so the design cannot lean on a stale instruction
  always @(posedge clk_sys)
  begin
    cmdValid <= issue && !reset;
    cmd      <= issue ? issueCmd : ~cmd;
  end
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
  $display("ERROR %0t: got %h want %h", $time, (g), (e)); end end
module tb;
  logic              clk_sys;
  logic              reset;
  logic              issue;
  cai_pkg::cai_cmd_t issueCmd;
  logic              cmdValid;
  cai_pkg::cai_cmd_t cmd;
  logic              opDone;
  logic [1:0]        condCode;
  logic              overflowFlag;
  logic [31:0]       accAOut;
  logic [31:0]       accBOut;
  logic [2:0]        regAddr;
  logic [31:0]       regWrData;
  logic              regWr;
  logic              regRd;
  logic [31:0]       regRdData;
  int                mismatches;
  int                tests_run;
  int                cycles;
  cai_seq_model seq_u (.clk_sys(clk_sys), .reset(reset), .issue(issue),
    .issueCmd(issueCmd), .cmdValid(cmdValid), .cmd(cmd));
  cai_compare_add #(.REG_AW(3)) dut_u (.clk_sys(clk_sys), .reset(reset), .cmdValid(cmdValid),
    .cmd(cmd), .opDone(opDone), .condCode(condCode), .overflowFlag(overflowFlag),
    .accAOut(accAOut), .accBOut(accBOut), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    regWr     <= 1'b1;
    regAddr   <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    `CHK(regRdData, e)
  endtask
  task automatic ab(input logic [31:0] a, input logic [31:0] b);
    wr(cai_pkg::OFS_ACCA, a);
    wr(cai_pkg::OFS_ACCB, b);
  endtask
  // one instruction through the sequencer model, then condition and primary checked
  task automatic op(input logic [6:0] o, input logic [1:0] m, input logic c, input logic l,
    input logic [17:0] a, input logic [63:0] mm, input logic [1:0] ec, input logic [31:0] ea);
    int n;
    @(posedge clk_sys);
    issue    <= 1'b1;
    issueCmd <= '{o, m, c, l, a, mm};
    @(posedge clk_sys);
    issue <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end while (opDone !== 1'b1 && n < 4);
    `CHK(opDone, 1'b1)
    `CHK(condCode, ec)
    `CHK(accAOut, ea)
  endtask
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  // hang guard: the whole sequence needs well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      end_of_test();
    end
  end
  initial
  begin
    logic [1:0] bx[4];
    logic [1:0] zx[4];
    bx = '{2'h1, 2'h1, 2'h2, 2'h3};
    zx = '{2'h0, 2'h2, 2'h1, 2'h3};
    reset = 1'b1; issue = 1'b0; issueCmd = '0; regAddr = 3'h0;
    regWrData = 32'h0000_0000; regWr = 1'b0; regRd = 1'b0; mismatches = 0; tests_run = 0;
    cycles = 0;
    repeat (5) @(posedge clk_sys);
    reset <= 1'b0;
    rd(cai_pkg::OFS_ACCA, 32'h0000_0000);
    rd(cai_pkg::OFS_STATUS, 32'h0000_0000);
    rd(3'h7, 32'h0000_0000);
    ab(32'h1234_5678, 32'h0000_00FF);
    for (int i = 0; i < 4; i++)
      op(cai_pkg::OPC_CMP_BYTE, i[1:0], 1, 0, 0, 64'h56, bx[i], 32'h1234_5678);
    op(cai_pkg::OPC_CMP_BYTE, 2'h3, 1, 1, 18'h3_FF78, 0, 2'h2, 32'h1234_5678);
    wr(cai_pkg::OFS_STATUS, 32'h0000_0001);
    op(cai_pkg::OPC_CMP_BYTE, 2'h3, 0, 0, 0, 0, 2'h1, 32'h1234_5678);
    op(cai_pkg::OPC_CMP_SEL, 2'h0, 0, 0, 0, 0, 2'h1, 32'h1234_5678);
    op(cai_pkg::OPC_CMP_SEL, 2'h2, 1, 0, 0, 64'h78, 2'h2, 32'h1234_5678);
    op(cai_pkg::OPC_CMP_SEL, 2'h1, 1, 0, 0, 64'h87, 2'h1, 32'h1234_5678);
    op(cai_pkg::OPC_CMP_SEL, 2'h0, 1, 0, 0, 64'h70, 2'h3, 32'h1234_5678);
    $display("test byte and selective compare done");
    ab(32'h0000_0000, 32'hFFFF_FFFF);
    op(cai_pkg::OPC_CMP_ZERO, 2'h0, 1, 1, 0, 64'h8000_0000, 2'h1, 0);
    for (int i = 1; i < 4; i++)
      op(cai_pkg::OPC_CMP_ZERO, i[1:0], 1, 0, 18'h2_0000, 0, zx[i], 0);
    op(cai_pkg::OPC_CMP_SEL, 2'h0, 1, 0, 0, 64'h1, 2'h3, 0);
    ab(32'h0000_0000, 32'h0000_0000);
    op(cai_pkg::OPC_CMP_SEL, 2'h0, 1, 0, 0, 64'hFFFF_FFFF, 2'h2, 0);
    wr(cai_pkg::OFS_IDX1, 32'h0000_0100);
    wr(cai_pkg::OFS_IDX3, 32'h0003_FFFF);
    op(cai_pkg::OPC_CMP_INDEX, 2'h1, 1, 0, 0, 64'h100, 2'h2, 0);
    op(cai_pkg::OPC_CMP_INDEX, 2'h1, 1, 0, 0, 64'hFFFF_FFFF, 2'h1, 0);
    op(cai_pkg::OPC_CMP_INDEX, 2'h1, 1, 1, 18'h0_00FF, 0, 2'h3, 0);
    op(cai_pkg::OPC_CMP_INDEX, 2'h3, 1, 0, 0, 64'h3_FFFF, 2'h2, 0);
    ab(32'hFFFE_0000, 32'hFFFF_0000);
    op(cai_pkg::OPC_CMP_SEL, 2'h0, 1, 1, 18'h2_0000, 0, 2'h2, 32'hFFFE_0000);
    ab(32'h1234_5678, 32'h8000_0000);
    op(cai_pkg::OPC_CMP_ALG, 2'h1, 1, 0, 0, 64'hFFFF_FFFF, 2'h3, 32'h1234_5678);
    op(cai_pkg::OPC_CMP_ALG, 2'h2, 1, 0, 0, 64'h1, 2'h1, 32'h1234_5678);
    op(cai_pkg::OPC_CMP_ALG, 2'h1, 1, 1, 18'h2_0000, 0, 2'h3, 32'h1234_5678);
    ab(32'hFFFF_FFFF, 32'hFFFE_0000);
    op(cai_pkg::OPC_CMP_ALG, 2'h3, 1, 1, 18'h2_0000, 0, 2'h2, 32'hFFFF_FFFF);
    $display("test zero, index and signed compare done");
    wr(cai_pkg::OFS_STATUS, 32'h0000_0004);
    ab(32'h7FFF_FFFF, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_ACC, 2'h1, 1, 0, 0, 64'h1, 2'h1, 32'h8000_0000);
    rd(cai_pkg::OFS_STATUS, 32'h0000_0005);
    `CHK(overflowFlag, 1'b1)
    wr(cai_pkg::OFS_STATUS, 32'h0000_0004);
    op(cai_pkg::OPC_ADD_ACC, 2'h1, 0, 0, 0, 64'h1, 2'h0, 32'h8000_0001);
    rd(cai_pkg::OFS_STATUS, 32'h0000_0000);
    `CHK(overflowFlag, 1'b0)
    ab(32'h0000_0000, 32'hFFFF_FFFF);
    op(cai_pkg::OPC_ADD_ACC, 2'h3, 1, 0, 0, 64'h1, 2'h3, 32'h0000_0001);
    `CHK(accBOut, 32'h0000_0000)
    ab(32'h0000_0000, 32'h0000_0005);
    op(cai_pkg::OPC_ADD_ACC, 2'h2, 1, 1, 18'h3_FFFF, 0, 2'h3, 0);
    `CHK(accBOut, 32'h0000_0004)
    ab(32'h0001_FFFF, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_HALF, 2'h3, 1, 0, 0, 64'h1, 2'h3, 32'h0002_0000);
    ab(32'h0000_FFFF, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_HALF, 2'h2, 1, 0, 0, 64'h1, 2'h2, 32'h0000_0000);
    ab(32'h7FFF_0000, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_HALF, 2'h1, 1, 0, 0, 64'h1, 2'h1, 32'h8000_0000);
    rd(cai_pkg::OFS_STATUS, 32'h0000_0005);
    wr(cai_pkg::OFS_STATUS, 32'h0000_0004);
    ab(32'h7FFF_0000, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_HALF, 2'h1, 1, 0, 0, 64'h0, 2'h3, 32'h7FFF_0000);
    rd(cai_pkg::OFS_STATUS, 32'h0000_0003);
    ab(32'h7FFF_0000, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_HALF, 2'h3, 1, 0, 0, 64'h7FFF_0000, 2'h3, 32'h7FFF_0000);
    ab(32'h7FFF_FFFF, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_HALF, 2'h3, 1, 0, 0, 64'h1, 2'h1, 32'h8000_0000);
    rd(cai_pkg::OFS_STATUS, 32'h0000_0005);
    ab(32'h0000_0005, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_HALF, 2'h3, 1, 1, 18'h0_FFFF, 0, 2'h3, 32'h0000_0004);
    ab(32'h0000_00FF, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_BYTE, 2'h3, 1, 0, 0, 64'h1, 2'h3, 32'h0000_0100);
    ab(32'h0012_0000, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_BYTE, 2'h1, 1, 0, 0, 64'h34, 2'h3, 32'h0046_0000);
    ab(32'hFF00_0000, 32'h0000_0000);
    op(cai_pkg::OPC_ADD_BYTE, 2'h0, 1, 0, 0, 64'h1, 2'h2, 32'h0000_0000);
    $display("test add family done");
    end_of_test();
  end
endmodule
bind cai_compare_add cai_compare_add_monitor #(.REG_AW(REG_AW)) mon_u (.clk_sys(clk_sys),
  .reset(reset), .cmdValid(cmdValid), .cmd(cmd), .opDone(opDone), .condCode(condCode),
  .overflowFlag(overflowFlag), .accAOut(accAOut), .accBOut(accBOut), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData));
`default_nettype wire
